// [hw/pfc_framer.sv]
// Implementation choice: the APB interface to the registers.
`timescale 1ns/1ps
module pfc_framer (
  // APB slave.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Neighbouring configuration.
  input wire logic [7:0] sync_upper_byte,
  input wire logic [4:0] sync_length,
  input wire logic [7:0] length_limit,
  // Transmit packet RAM read port, one cycle latency.
  output logic [7:0] tx_ram_addr,
  input wire logic [7:0] tx_ram_rdata,
  // Receive packet RAM write port.
  output pfc_pkg::pfc_ram_wr_t rx_ram_wr,
  // Modem side.
  input wire logic tx_bit_req,
  output logic tx_bit,
  output logic tx_busy,
  input wire logic rx_bit,
  input wire logic rx_bit_valid,
  input wire logic preamble_det,
  input wire logic sync_det,
  input wire logic stream_end,
  output logic rx_stream_en,
  output logic event_output_pin,
  output logic irq
);

  // ***********************************************
  // Registers and APB decode.
  // ***********************************************
  logic [7:0] sync_mid_r;
  logic [7:0] sync_low_r;
  logic [7:0] transmit_frame_start_r;
  logic [7:0] receive_frame_start_r;
  pfc_pkg::pfc_fmt_t fmt_r;
  pfc_pkg::pfc_irq_t stat_r;
  pfc_pkg::pfc_irq_t mask_r;
  pfc_pkg::pfc_irq_t set_ev;
  logic [31:0] prdata_r;
  logic [8:0] idx;
  logic wr_acc;
  logic rd_acc;
  logic mapped;
  logic tx_go;

  assign idx = paddr[pfc_pkg::ADDR_MSB:pfc_pkg::ADDR_LSB];
  assign mapped = (idx == pfc_pkg::IDX_SYNC_MID) || (idx == pfc_pkg::IDX_SYNC_LOW) ||
                  (idx == pfc_pkg::IDX_TX_PTR) || (idx == pfc_pkg::IDX_RX_PTR) ||
                  (idx == pfc_pkg::IDX_FMT) || (idx == pfc_pkg::IDX_IRQ_STAT) ||
                  (idx == pfc_pkg::IDX_IRQ_MASK) || (idx == pfc_pkg::IDX_CMD);
  assign wr_acc = psel && penable && pwrite && mapped;
  assign rd_acc = psel && penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign prdata = prdata_r;
  assign tx_go = wr_acc && (idx == pfc_pkg::IDX_CMD) && pwdata[pfc_pkg::CMD_TX_GO];
  assign irq = |(stat_r & mask_r);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync_mid_r <= pfc_pkg::REG_RST;
      sync_low_r <= pfc_pkg::REG_RST;
      transmit_frame_start_r <= pfc_pkg::REG_RST;
      receive_frame_start_r <= pfc_pkg::REG_RST;
      fmt_r <= pfc_pkg::REG_RST;
      mask_r <= pfc_pkg::IRQ_RST;
    end
    else if (wr_acc)
    begin
      unique case (idx)
        pfc_pkg::IDX_SYNC_MID: sync_mid_r <= pwdata[7:0];
        pfc_pkg::IDX_SYNC_LOW: sync_low_r <= pwdata[7:0];
        pfc_pkg::IDX_TX_PTR: transmit_frame_start_r <= pwdata[7:0];
        pfc_pkg::IDX_RX_PTR: receive_frame_start_r <= pwdata[7:0];
        pfc_pkg::IDX_FMT: fmt_r <= pwdata[7:0];
        pfc_pkg::IDX_IRQ_MASK: mask_r <= pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Read data is latched in the setup cycle so the bus sees a flop output.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata_r <= '0;
    else if (psel && !penable && !pwrite)
    begin
      unique case (idx)
        pfc_pkg::IDX_SYNC_MID: prdata_r <= {24'h000000, sync_mid_r};
        pfc_pkg::IDX_SYNC_LOW: prdata_r <= {24'h000000, sync_low_r};
        pfc_pkg::IDX_TX_PTR: prdata_r <= {24'h000000, transmit_frame_start_r};
        pfc_pkg::IDX_RX_PTR: prdata_r <= {24'h000000, receive_frame_start_r};
        pfc_pkg::IDX_FMT: prdata_r <= {24'h000000, fmt_r};
        pfc_pkg::IDX_IRQ_STAT: prdata_r <= {28'h0000000, stat_r};
        pfc_pkg::IDX_IRQ_MASK: prdata_r <= {28'h0000000, mask_r};
        default: prdata_r <= '0;
      endcase
    end
  end

  // A new event wins over the read that clears the status.
  // Only the bits latched for the reader are cleared, so an event landing at the setup edge is not lost.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      stat_r <= pfc_pkg::IRQ_RST;
    else if (rd_acc && (idx == pfc_pkg::IDX_IRQ_STAT))
      stat_r <= (stat_r & ~prdata_r[3:0]) | set_ev;
    else
      stat_r <= stat_r | set_ev;
  end

  // ***********************************************
  // Shared helpers.
  // ***********************************************
  function automatic logic [7:0] shift_in(input logic [7:0] sh, input logic b, input logic msb);
    shift_in = msb ? {sh[6:0], b} : {b, sh[7:1]};
  endfunction

  function automatic logic [7:0] shift_out(input logic [7:0] sh, input logic msb);
    shift_out = msb ? {sh[6:0], 1'b0} : {1'b0, sh[7:1]};
  endfunction

  // ***********************************************
  // Transmit path.
  // ***********************************************
  pfc_pkg::pfc_tx_st_t tx_st_r;
  logic [23:0] sync_pat;
  logic [4:0] sync_bit_r;
  logic [4:0] sync_top;
  logic [7:0] tx_sh_r;
  logic [2:0] tx_bit_cnt_r;
  logic [7:0] tx_left_r;
  logic [7:0] tx_sum_r;
  logic tx_wait_r;
  logic tx_bit_r;
  logic tx_done_ev;
  logic tx_byte_end;

  assign sync_pat = {sync_upper_byte, sync_mid_r, sync_low_r};
  assign sync_top = (sync_length >= pfc_pkg::SYNC_THREE_BYTE) ? pfc_pkg::SYNC_BITS_3 :
                    (sync_length >= pfc_pkg::SYNC_TWO_BYTE) ? pfc_pkg::SYNC_BITS_2 :
                    pfc_pkg::SYNC_BITS_1;
  assign tx_byte_end = tx_bit_req && (tx_bit_cnt_r == pfc_pkg::BIT_LAST);
  assign tx_bit = tx_bit_r;
  assign tx_busy = (tx_st_r != pfc_pkg::TX_IDLE);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      tx_st_r <= pfc_pkg::TX_IDLE;
      sync_bit_r <= '0;
      tx_sh_r <= '0;
      tx_bit_cnt_r <= '0;
      tx_left_r <= '0;
      tx_sum_r <= '0;
      tx_wait_r <= 1'b0;
      tx_bit_r <= 1'b0;
      tx_ram_addr <= '0;
      tx_done_ev <= 1'b0;
    end
    else
    begin
      tx_done_ev <= 1'b0;
      unique case (tx_st_r)
        pfc_pkg::TX_IDLE:
          if (tx_go && (fmt_r.path == pfc_pkg::PATH_PACKET))
          begin
            tx_ram_addr <= transmit_frame_start_r;
            tx_left_r <= length_limit;
            tx_sum_r <= '0;
            sync_bit_r <= sync_top;
            tx_st_r <= (sync_length >= pfc_pkg::SYNC_ONE_BYTE) ? pfc_pkg::TX_SYNC : pfc_pkg::TX_FETCH;
            tx_wait_r <= 1'b1;
          end
        pfc_pkg::TX_SYNC:
          if (tx_bit_req)
          begin
            tx_bit_r <= sync_pat[sync_bit_r];
            sync_bit_r <= sync_bit_r - 5'h01;
            if (sync_bit_r == 5'h00)
              tx_st_r <= pfc_pkg::TX_FETCH;
          end
        pfc_pkg::TX_FETCH:
          if (tx_left_r == 8'h00)
          begin
            tx_sh_r <= tx_sum_r;
            tx_bit_cnt_r <= pfc_pkg::BIT_FIRST;
            tx_st_r <= fmt_r.csum_en ? pfc_pkg::TX_CSUM : pfc_pkg::TX_IDLE;
            tx_done_ev <= !fmt_r.csum_en;
          end
          else if (tx_wait_r)
            tx_wait_r <= 1'b0;
          else
          begin
            tx_sh_r <= tx_ram_rdata;
            tx_sum_r <= tx_sum_r + tx_ram_rdata;
            tx_bit_cnt_r <= pfc_pkg::BIT_FIRST;
            tx_st_r <= pfc_pkg::TX_DATA;
          end
        pfc_pkg::TX_DATA, pfc_pkg::TX_CSUM:
          if (tx_bit_req)
          begin
            tx_bit_r <= fmt_r.msb_first ? tx_sh_r[7] : tx_sh_r[0];
            tx_sh_r <= shift_out(tx_sh_r, fmt_r.msb_first);
            tx_bit_cnt_r <= tx_bit_cnt_r + 3'h1;
            if (tx_byte_end && (tx_st_r == pfc_pkg::TX_CSUM))
            begin
              tx_st_r <= pfc_pkg::TX_IDLE;
              tx_done_ev <= 1'b1;
            end
            else if (tx_byte_end)
            begin
              tx_left_r <= tx_left_r - 8'h01;
              tx_ram_addr <= tx_ram_addr + 8'h01;
              tx_wait_r <= 1'b1;
              tx_st_r <= pfc_pkg::TX_FETCH;
            end
          end
      endcase
    end
  end

  // ***********************************************
  // Receive path.
  // ***********************************************
  pfc_pkg::pfc_rx_st_t rx_st_r;
  logic [7:0] rx_sh_r;
  logic [7:0] rx_byte;
  logic [2:0] rx_bit_cnt_r;
  logic [7:0] rx_idx_r;
  logic [7:0] rx_target_r;
  logic [7:0] rx_sum_r;
  logic [7:0] var_len;
  logic [7:0] tgt;
  logic rx_byte_end;
  logic rx_good_ev;
  logic rx_bad_ev;
  logic is_stream;

  assign rx_byte = shift_in(rx_sh_r, rx_bit, fmt_r.msb_first);
  assign rx_byte_end = rx_bit_valid && (rx_bit_cnt_r == pfc_pkg::BIT_LAST);
  // Wraps if field plus adjust is under four; the limit then caps it.
  assign var_len = rx_byte + {5'h00, fmt_r.len_adj} - pfc_pkg::LEN_BIAS;
  assign tgt = (rx_idx_r == 8'h00 && !fmt_r.fixed_len) ?
               ((var_len > length_limit) ? length_limit : var_len) : rx_target_r;
  assign is_stream = (fmt_r.path == pfc_pkg::PATH_STREAM_PRE) ||
                     (fmt_r.path == pfc_pkg::PATH_STREAM_SYNC);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      rx_st_r <= pfc_pkg::RX_IDLE;
      rx_sh_r <= '0;
      rx_bit_cnt_r <= '0;
      rx_idx_r <= '0;
      rx_target_r <= '0;
      rx_sum_r <= '0;
      rx_ram_wr <= '0;
      rx_good_ev <= 1'b0;
      rx_bad_ev <= 1'b0;
    end
    else
    begin
      rx_ram_wr.we <= 1'b0;
      rx_good_ev <= 1'b0;
      rx_bad_ev <= 1'b0;
      if (rx_bit_valid)
      begin
        rx_sh_r <= rx_byte;
        rx_bit_cnt_r <= rx_bit_cnt_r + 3'h1;
      end
      unique case (rx_st_r)
        pfc_pkg::RX_IDLE:
          if (sync_det && (fmt_r.path == pfc_pkg::PATH_PACKET))
          begin
            rx_bit_cnt_r <= pfc_pkg::BIT_FIRST;
            rx_idx_r <= '0;
            rx_sum_r <= '0;
            rx_target_r <= length_limit;
            rx_st_r <= pfc_pkg::RX_DATA;
          end
        pfc_pkg::RX_DATA:
          if (rx_byte_end)
          begin
            rx_ram_wr.we <= 1'b1;
            rx_ram_wr.addr <= receive_frame_start_r + rx_idx_r;
            rx_ram_wr.data <= rx_byte;
            rx_sum_r <= rx_sum_r + rx_byte;
            rx_idx_r <= rx_idx_r + 8'h01;
            rx_target_r <= tgt;
            if ((rx_idx_r + 8'h01) >= tgt)
            begin
              rx_st_r <= fmt_r.csum_en ? pfc_pkg::RX_CSUM : pfc_pkg::RX_IDLE;
              rx_good_ev <= !fmt_r.csum_en;
            end
          end
        pfc_pkg::RX_CSUM:
          if (rx_byte_end)
          begin
            rx_st_r <= pfc_pkg::RX_IDLE;
            rx_good_ev <= (rx_byte == rx_sum_r);
            rx_bad_ev <= (rx_byte != rx_sum_r);
          end
      endcase
    end
  end

  // ***********************************************
  // Serial stream event pin and data gate.
  // ***********************************************
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      event_output_pin <= 1'b0;
      rx_stream_en <= 1'b0;
    end
    else
    begin
      event_output_pin <= ((fmt_r.path == pfc_pkg::PATH_STREAM_PRE) && preamble_det) ||
                          ((fmt_r.path == pfc_pkg::PATH_STREAM_SYNC) && sync_det);
      if (is_stream && preamble_det)
        rx_stream_en <= 1'b1;
      else if (stream_end || !is_stream)
        rx_stream_en <= 1'b0;
    end
  end

  assign set_ev = '{event_seen: event_output_pin, rx_bad: rx_bad_ev, rx_good: rx_good_ev, tx_done: tx_done_ev};

endmodule

// [hw/pfc_pkg.sv]
package pfc_pkg;

  // ***********************************************
  // Register indices; byte address is four times the index.
  // ***********************************************
  localparam logic [8:0] IDX_SYNC_MID = 9'h122;
  localparam logic [8:0] IDX_SYNC_LOW = 9'h123;
  localparam logic [8:0] IDX_TX_PTR = 9'h124;
  localparam logic [8:0] IDX_RX_PTR = 9'h125;
  localparam logic [8:0] IDX_FMT = 9'h126;
  localparam logic [8:0] IDX_IRQ_STAT = 9'h130;
  localparam logic [8:0] IDX_IRQ_MASK = 9'h131;
  localparam logic [8:0] IDX_CMD = 9'h132;
  localparam int ADDR_LSB = 2;
  localparam int ADDR_MSB = 10;

  // ***********************************************
  // Fields, reset values and constants.
  // ***********************************************
  localparam logic [7:0] REG_RST = 8'h00;
  localparam logic [3:0] IRQ_RST = 4'h0;
  localparam logic [7:0] LEN_BIAS = 8'h04;
  localparam logic [1:0] PATH_PACKET = 2'h0;
  localparam logic [1:0] PATH_STREAM_PRE = 2'h1;
  localparam logic [1:0] PATH_STREAM_SYNC = 2'h2;
  localparam logic [4:0] SYNC_ONE_BYTE = 5'h01;
  localparam logic [4:0] SYNC_TWO_BYTE = 5'h08;
  localparam logic [4:0] SYNC_THREE_BYTE = 5'h10;
  localparam logic [4:0] SYNC_BITS_1 = 5'h07;
  localparam logic [4:0] SYNC_BITS_2 = 5'h0f;
  localparam logic [4:0] SYNC_BITS_3 = 5'h17;
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [2:0] BIT_FIRST = 3'h0;
  localparam int CMD_TX_GO = 0;

  typedef struct packed {
    logic msb_first;
    logic fixed_len;
    logic csum_en;
    logic [1:0] path;
    logic [2:0] len_adj;
  } pfc_fmt_t;

  typedef struct packed {
    logic event_seen;
    logic rx_bad;
    logic rx_good;
    logic tx_done;
  } pfc_irq_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] data;
    logic we;
  } pfc_ram_wr_t;

  typedef enum logic [4:0] {
    TX_IDLE = 5'b00001,
    TX_SYNC = 5'b00010,
    TX_FETCH = 5'b00100,
    TX_DATA = 5'b01000,
    TX_CSUM = 5'b10000
  } pfc_tx_st_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_DATA = 3'b010,
    RX_CSUM = 3'b100
  } pfc_rx_st_t;

endpackage

// [tb/pfc_framer_chk.sv]
`timescale 1ns/1ps
// ****************
// Port checker.
// ****************
module pfc_framer_chk (
  // Clock and bus.
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pslverr,
  // Modem side.
  input wire logic tx_bit_req,
  input wire logic tx_bit,
  input wire logic tx_busy,
  input wire logic rx_bit_valid,
  input wire pfc_pkg::pfc_ram_wr_t rx_ram_wr,
  input wire logic preamble_det,
  input wire logic sync_det,
  input wire logic stream_end,
  input wire logic rx_stream_en,
  input wire logic event_output_pin
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("error outside access");
  property p_evt; event_output_pin |-> $past(preamble_det || sync_det) || $past(preamble_det || sync_det, 2); endproperty
  a_evt: assert property (p_evt) else $error("event without detection");
  property p_strm; $rose(rx_stream_en) |-> $past(preamble_det) || $past(preamble_det, 2); endproperty
  a_strm: assert property (p_strm) else $error("stream without preamble");
  property p_sclr; $fell(rx_stream_en) |-> $past(stream_end || (psel && penable && pwrite)); endproperty
  a_sclr: assert property (p_sclr) else $error("stream dropped without cause");
  property p_wr; rx_ram_wr.we |-> $past(rx_bit_valid) || $past(rx_bit_valid, 2); endproperty
  a_wr: assert property (p_wr) else $error("write without bit");
  property p_wr1; rx_ram_wr.we |=> !rx_ram_wr.we; endproperty
  a_wr1: assert property (p_wr1) else $error("write pulse too long");
  property p_txb; tx_busy && $past(tx_busy) && $changed(tx_bit) |-> $past(tx_bit_req); endproperty
  a_txb: assert property (p_txb) else $error("bit moved without request");
  property p_go; $rose(tx_busy) |-> $past(psel && penable && pwrite); endproperty
  a_go: assert property (p_go) else $error("transmit without command");
endmodule
bind pfc_framer pfc_framer_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .pslverr, .tx_bit_req, .tx_bit,
  .tx_busy, .rx_bit_valid, .rx_ram_wr, .preamble_det, .sync_det, .stream_end, .rx_stream_en, .event_output_pin);

// [tb/pfc_modem.sv]
`timescale 1ns/1ps
// ****************
// Far-side modem and packet RAM.
// ****************
module pfc_modem (
  // Clock.
  input wire logic pclk,
  // Transmit side.
  input wire logic tx_busy,
  input wire logic tx_bit,
  input wire logic [7:0] tx_ram_addr,
  output logic [7:0] tx_ram_rdata,
  output logic tx_bit_req,
  // Receive side.
  input wire pfc_pkg::pfc_ram_wr_t rx_ram_wr,
  output logic rx_bit,
  output logic rx_bit_valid
);
  logic [7:0] mem [256];
  logic tx_q [$];
  int gap = 4;
  initial
  begin
    tx_bit_req = 0;
    rx_bit = 0;
    rx_bit_valid = 0;
  end
  always @(posedge pclk)
  begin
    tx_ram_rdata <= mem[tx_ram_addr];
    if (rx_ram_wr.we === 1'b1)
      mem[rx_ram_wr.addr] <= rx_ram_wr.data;
  end
  // Requests stay four or more clocks apart, so none falls into a byte fetch.
  initial forever
  begin
    @(posedge pclk);
    if (tx_busy === 1'b1)
    begin
      tx_bit_req <= 1;
      @(posedge pclk);
      tx_bit_req <= 0;
      @(posedge pclk);
      tx_q.push_back(tx_bit);
      repeat (gap - 2) @(posedge pclk);
    end
  end
  task send_byte(input logic [7:0] b, input logic f);
    for (int j = 0; j < 8; j++)
    begin
      @(posedge pclk);
      rx_bit <= f ? b[7 - j] : b[j];
      rx_bit_valid <= 1;
      @(posedge pclk);
      rx_bit_valid <= 0;
      rx_bit <= ~rx_bit;
      @(posedge pclk);
    end
  endtask
endmodule

// [tb/pfc_framer_tb_top.sv]
`timescale 1ns/1ps
// ****************
// Self-checking bench.
// ****************
module pfc_framer_tb_top;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err, ev, m, irq;
  logic tx_bit_req, tx_bit, tx_busy, rx_bit, rx_bit_valid, preamble_det, sync_det, stream_end;
  logic rx_stream_en, event_output_pin;
  logic [31:0] paddr, pwdata, prdata, rd;
  logic [7:0] sync_upper_byte, length_limit, tx_ram_addr, tx_ram_rdata, s;
  logic [7:0] rv [5];
  logic [7:0] fr [8];
  logic [4:0] sync_length;
  logic [2:0] adj;
  pfc_pkg::pfc_ram_wr_t rx_ram_wr;
  int failures, check_count, seed, i, t, k, n;
  logic exp_q [$];
  pfc_framer u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .sync_upper_byte, .sync_length, .length_limit, .tx_ram_addr, .tx_ram_rdata, .rx_ram_wr, .tx_bit_req, .tx_bit,
    .tx_busy, .rx_bit, .rx_bit_valid, .preamble_det, .sync_det, .stream_end, .rx_stream_en, .event_output_pin, .irq);
  pfc_modem u_mdm (.pclk, .tx_busy, .tx_bit, .tx_ram_addr, .tx_ram_rdata, .tx_bit_req, .rx_ram_wr, .rx_bit,
    .rx_bit_valid);
  initial
  begin
    pclk = 0;
    forever #2 pclk = ~pclk;
  end
  initial
  begin
    #100000;
    failures++;
    finish_test;
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task finish_test;
    $display("failures %0d checks %0d", failures, check_count);
    if (failures == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task apb(input logic w, input logic [8:0] x, input logic [7:0] d);
    psel <= 1;
    pwrite <= w;
    paddr <= {21'h0, x, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
    @(posedge pclk);
  endtask
  task pulse(input logic [2:0] w);
    {preamble_det, sync_det, stream_end} <= w;
    @(posedge pclk);
    {preamble_det, sync_det, stream_end} <= 3'h0;
    ev = 0;
    repeat (3)
    begin
      @(posedge pclk);
      ev = ev | event_output_pin;
    end
  endtask
  function automatic void add(input logic [7:0] v, input logic f);
    for (int j = 0; j < 8; j++) exp_q.push_back(f ? v[7 - j] : v[j]);
  endfunction
  initial
  begin
    seed = 2;
    {presetn, psel, penable, pwrite, preamble_det, sync_det, stream_end} = 0;
    paddr = 0;
    pwdata = 0;
    sync_length = 5'h18;
    sync_upper_byte = 8'($random(seed));
    length_limit = 8'h06;
    repeat (5) @(posedge pclk);
    presetn <= 1;
    @(posedge pclk);
    for (i = 0; i < 5; i++)
    begin
      rv[i] = 8'($random(seed));
      apb(1, pfc_pkg::IDX_SYNC_MID + 9'(i), rv[i]);
    end
    for (i = 0; i < 5; i++)
    begin
      apb(0, pfc_pkg::IDX_SYNC_MID + 9'(i), 8'h00);
      chk("register", {24'h0, rv[i]}, rd);
    end
    apb(0, 9'h127, 8'h00);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1, pfc_pkg::IDX_IRQ_MASK, 8'h0f);
    // Second frame uses the other bit order, a slow modem, a two-byte sync and no checksum.
    for (t = 0; t < 2; t++)
    begin
      m = t[0];
      length_limit <= 8'h03 + 8'(t);
      sync_length <= t ? 5'h0c : 5'h18;
      exp_q.delete();
      u_mdm.tx_q.delete();
      u_mdm.gap = 4 + 3 * t;
      if (t == 0)
        add(sync_upper_byte, 1);
      add(rv[0], 1);
      add(rv[1], 1);
      s = 0;
      for (k = 0; k < 3 + t; k++)
      begin
        fr[k] = 8'($random(seed));
        u_mdm.mem[rv[2] + 8'(k)] = fr[k];
        add(fr[k], m);
        s += fr[k];
      end
      if (t == 0)
        add(s, m);
      apb(1, pfc_pkg::IDX_FMT, {m, t[0], !t[0], 5'h0});
      apb(1, pfc_pkg::IDX_CMD, 8'h01);
      while (tx_busy !== 1'b0) @(posedge pclk);
      repeat (4) @(posedge pclk);
      chk("tx bits", exp_q.size(), u_mdm.tx_q.size());
      for (k = 0; k < exp_q.size(); k++) chk("tx bit", exp_q[k], u_mdm.tx_q[k]);
      chk("irq", 1, irq);
      apb(0, pfc_pkg::IDX_IRQ_STAT, 8'h00);
      chk("tx status", 32'h1, rd);
      chk("irq clear", 0, irq);
    end
    apb(1, pfc_pkg::IDX_FMT, 8'h08);
    apb(1, pfc_pkg::IDX_CMD, 8'h01);
    chk("refused start", 0, tx_busy);
    // Second frame overruns the limit and carries a broken checksum; the third is fixed length without one.
    length_limit <= 8'h06;
    for (t = 0; t < 3; t++)
    begin
      adj = 3'($random(seed));
      fr[0] = t ? 8'hc8 : 8'h07 - 8'(adj) + 8'($random(seed) & 3);
      n = t ? 6 : fr[0] + adj - 4;
      m = 1'($random(seed));
      apb(1, pfc_pkg::IDX_FMT, {m, t == 2, t != 2, 2'b00, adj});
      s = 0;
      for (k = 0; k < n; k++)
      begin
        if (k > 0)
          fr[k] = 8'($random(seed));
        s += fr[k];
      end
      pulse(3'b010);
      for (k = 0; k < n; k++) u_mdm.send_byte(fr[k], m);
      if (t < 2)
        u_mdm.send_byte(t ? ~s : s, m);
      repeat (4) @(posedge pclk);
      for (k = 0; k < n; k++) chk("rx byte", fr[k], u_mdm.mem[rv[3] + 8'(k)]);
      apb(0, pfc_pkg::IDX_IRQ_STAT, 8'h00);
      chk("rx status", (t == 1) ? 32'h4 : 32'h2, rd & 32'h6);
    end
    for (t = 1; t < 3; t++)
    begin
      apb(1, pfc_pkg::IDX_FMT, {3'h0, 2'(t), 3'h0});
      pulse(3'b100);
      chk("preamble event", t == 1, ev);
      chk("stream on", 1, rx_stream_en);
      pulse(3'b010);
      chk("sync event", t == 2, ev);
      pulse(3'b001);
      chk("stream off", 0, rx_stream_en);
    end
    finish_test;
  end
endmodule
